// File: design/tcdp_chan_if.sv
// Purpose: carrier between the register side and one modulator channel
// Assumes: single clock domain
// Notes: tick is a one-cycle counting clock enable
`timescale 1ns/1ps
`default_nettype none
interface tcdp_chan_if;
  logic       ce;
  logic       tick;
  logic       run;
  logic [7:0] period;
  logic [7:0] duty_hi;
  logic [1:0] duty_lo;
  logic       wave;

  modport ctl  (output ce, tick, run, period, duty_hi, duty_lo, input wave);
  modport chan (input ce, tick, run, period, duty_hi, duty_lo, output wave);
endinterface
`default_nettype wire

// File: design/tcdp_channel.sv
// Purpose: one modulator channel: base counter, dither phase, waveform
// Assumes: tick only high while ce is high
// Notes: the delayed rise shortens the high time by one counting clock
`timescale 1ns/1ps
`default_nettype none
module tcdp_channel
  import tcdp_pkg::*;
(
  input  wire logic   clk_in,   // system clock
  input  wire logic   rst_n_in, // async reset, active low
  tcdp_chan_if.chan   c         // channel controls and waveform
);
  typedef struct packed {
    logic [7:0] cnt;
    logic [1:0] phase;
    logic       late;
    logic       wave;
  } tcdp_chan_state_t;

  tcdp_chan_state_t s;
  tcdp_chan_state_t next_s;
  logic             wrap;
  logic             delay;

  // spreads the delayed periods evenly across four
  function automatic logic late_phase(input logic [1:0] lsb, input logic [1:0] ph);
    case (lsb)
      2'h1:    late_phase = (ph == 2'h0);
      2'h2:    late_phase = !ph[0];
      2'h3:    late_phase = (ph != 2'h3);
      default: late_phase = 1'b0;
    endcase
  endfunction

  always_comb begin
    next_s = s;
    wrap   = (s.cnt == c.period);
    delay  = late_phase(c.duty_lo, 2'(s.phase + 2'h1));
    if (!c.run) begin
      next_s = '0;
    end else if (c.tick) begin
      if (wrap) begin
        next_s.cnt   = 8'h00;
        next_s.phase = 2'(s.phase + 2'h1);
      end else begin
        next_s.cnt = 8'(s.cnt + 8'h01);
      end
      if (next_s.cnt == c.duty_hi) begin
        next_s.wave = 1'b0;
        next_s.late = 1'b0;
      end else if (wrap) begin
        next_s.wave = !delay;
        next_s.late = delay;
      end else if (s.late) begin
        next_s.wave = 1'b1;
        next_s.late = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else if (c.ce) begin
      s <= next_s;
    end
  end

  assign c.wave = s.wave;

  a_low_match : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (c.ce && c.run && c.tick && next_s.cnt == c.duty_hi) |=> !s.wave)
    else $error("waveform not low at duty match");

  a_count_wrap : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (c.ce && c.run && c.tick && s.cnt == c.period)
      |=> (s.cnt == 8'h00 && s.phase == 2'($past(s.phase) + 2'h1)))
    else $error("base counter did not roll over at period");

  c_late_rise : cover property (@(posedge clk_in) disable iff (!rst_n_in)
    s.late ##[1:8] s.wave);
endmodule
`default_nettype wire

// File: design/tcdp_pkg.sv
// Purpose: constants and types of the three-channel dithered modulator block
// Assumes: special-function register port, 100 MHz clk_in, one clock domain
// Notes: register offsets are the byte addresses of the register port
`default_nettype none
package tcdp_pkg;

  localparam int unsigned CHAN_N = 3;

  localparam logic [7:0] OFF_PERIOD [CHAN_N] = '{8'h9a, 8'h9c, 8'h9e};
  localparam logic [7:0] OFF_DUTY_HIGH [CHAN_N] = '{8'h9b, 8'h9d, 8'h9f};
  localparam logic [7:0] OFF_CON01 = 8'ha1;
  localparam logic [7:0] OFF_PINS = 8'ha6;
  localparam logic [7:0] OFF_CON2 = 8'ha7;
  localparam logic [7:0] OFF_AUXILIARY_CONTROL_ONE = 8'hf8;

  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [7:0] DUTY_HIGH_RST = 8'h00;
  localparam logic [7:0] CON01_RST = 8'h88;
  localparam logic [7:0] CON2_RST = 8'h08;
  localparam logic [7:0] PINS_RST = 8'h00;
  localparam logic [7:0] AUXILIARY_CONTROL_ONE_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // field positions: channel 2 fields live in the second control register
  localparam int unsigned CKS_LSB [CHAN_N] = '{2, 6, 2};
  localparam int unsigned DL_LSB [CHAN_N] = '{0, 4, 0};
  localparam int unsigned OE_BIT [CHAN_N] = '{6, 7, 4};
  localparam int unsigned CLEAR_BIT = 3;
  localparam logic [7:0] PINS_MASK = 8'hc0;
  localparam logic [7:0] CON2_MASK = 8'h1f;
  localparam logic [7:0] AUXILIARY_CONTROL_ONE_MASK = 8'h08;

  typedef enum logic [1:0] {
    CKS_DIV4 = 2'h0,
    CKS_DIV2 = 2'h1,
    CKS_DIV1 = 2'h2,
    CKS_FRC  = 2'h3
  } tcdp_cks_t;

  localparam logic [1:0] DIV_LAST = 2'h3;

endpackage
`default_nettype wire

// File: design/tcdp_tick_gen.sv
// Purpose: counting clock enables for the four clock sources
// Assumes: fast RC oscillator arrives as a pulse synchronous to clk_in
// Notes: tick_out is indexed by the clock select code
`timescale 1ns/1ps
`default_nettype none
module tcdp_tick_gen
  import tcdp_pkg::*;
(
  input  wire logic       clk_in,    // system clock
  input  wire logic       rst_n_in,  // async reset, active low
  input  wire logic       ce_in,     // clock enable
  input  wire logic       frc_in,    // fast rc oscillator tick
  output logic      [3:0] tick_out   // enables per clock select code
);
  typedef struct packed {
    logic [1:0] div;
  } tcdp_tick_state_t;

  tcdp_tick_state_t s;
  tcdp_tick_state_t next_s;

  always_comb begin
    next_s     = s;
    next_s.div = 2'(s.div + 2'h1);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign tick_out[CKS_DIV4] = ce_in && (s.div == DIV_LAST);
  assign tick_out[CKS_DIV2] = ce_in && s.div[0];
  assign tick_out[CKS_DIV1] = ce_in;
  assign tick_out[CKS_FRC]  = ce_in && frc_in;

  a_div4_gap : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    tick_out[CKS_DIV4] |=> !tick_out[CKS_DIV4] ##1 !tick_out[CKS_DIV4])
    else $error("divide-by-4 enable fired too soon");
endmodule
`default_nettype wire

// File: design/tcdp_top.sv
// Purpose: three dithered modulator channels behind special-function registers
// Assumes: register port and fast rc tick are synchronous to clk_in
// Notes: pin outputs lag the channel waveform by one clock
`timescale 1ns/1ps
`default_nettype none
module tcdp_top
  import tcdp_pkg::*;
(
  input  wire logic       clk_in,               // 100 MHz system clock
  input  wire logic       rst_n_in,             // async reset, active low
  input  wire logic       ce_in,                // clock enable, freezes all state
  input  wire logic [7:0] sfr_addr_in,          // register address
  input  wire logic       sfr_wr_in,            // register write strobe
  input  wire logic       sfr_rd_in,            // register read strobe
  input  wire logic [7:0] sfr_wdata_in,         // register write data
  output logic      [7:0] sfr_rdata_out,        // register read data, next cycle
  input  wire logic       fast_rc_oscillator_in,// fast rc oscillator tick
  input  wire logic [2:0] chan_open_drain_in,   // 1 open-drain, 0 push-pull
  output logic      [2:0] modulator_pin_out,    // pin drive level
  output logic      [2:0] modulator_pin_oe_out  // pin output enable
);

  typedef struct packed {
    logic [CHAN_N-1:0][7:0] period;
    logic [CHAN_N-1:0][7:0] duty_high;
    logic [7:0]             con01;
    logic [7:0]             con2;
    logic [7:0]             pins;
    logic [7:0]             auxiliary_control_one;
    logic [7:0]             rdata;
    logic [CHAN_N-1:0]      pin_out;
    logic [CHAN_N-1:0]      pin_oe;
  } tcdp_top_state_t;

  tcdp_top_state_t   s;
  tcdp_top_state_t   next_s;

  logic [3:0]        tick;
  logic [CHAN_N-1:0] wave;
  logic [CHAN_N-1:0] chan_oe;
  logic [CHAN_N-1:0] chan_run;
  logic [CHAN_N-1:0][1:0] cks;
  logic [CHAN_N-1:0][1:0] duty_lo;
  logic              clear0;

  tcdp_chan_if ch [CHAN_N] ();

  tcdp_tick_gen u_tick (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .frc_in   (fast_rc_oscillator_in),
    .tick_out (tick)
  );

  // only channel 0 has the clear-and-hold control
  assign clear0 = s.auxiliary_control_one[CLEAR_BIT];

  for (genvar i = 0; i < CHAN_N; i++) begin : g_chan
    logic [7:0] con;
    // channel 2 keeps its fields in the second control register
    assign con        = (i == 2) ? s.con2 : s.con01;
    assign cks[i]     = con[CKS_LSB[i] +: 2];
    assign duty_lo[i] = con[DL_LSB[i] +: 2];
    assign chan_oe[i] = (i == 2) ? s.con2[OE_BIT[i]] : s.pins[OE_BIT[i]];
    assign chan_run[i] = chan_oe[i] && !((i == 0) && clear0);

    assign ch[i].ce      = ce_in;
    assign ch[i].tick    = tick[cks[i]];
    assign ch[i].run     = chan_run[i];
    assign ch[i].period  = s.period[i];
    assign ch[i].duty_hi = s.duty_high[i];
    assign ch[i].duty_lo = duty_lo[i];
    assign wave[i]       = ch[i].wave;

    tcdp_channel u_chan (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .c        (ch[i])
    );
  end

  // register writes, read data and pin drive
  always_comb begin
    next_s = s;

    if (sfr_wr_in) begin
      for (int i = 0; i < CHAN_N; i++) begin
        if (sfr_addr_in == OFF_PERIOD[i]) begin
          next_s.period[i] = sfr_wdata_in;
        end else if (sfr_addr_in == OFF_DUTY_HIGH[i]) begin
          next_s.duty_high[i] = sfr_wdata_in;
        end
      end
      if (sfr_addr_in == OFF_CON01) begin
        next_s.con01 = sfr_wdata_in;
      end else if (sfr_addr_in == OFF_CON2) begin
        next_s.con2 = sfr_wdata_in & CON2_MASK;
      end else if (sfr_addr_in == OFF_PINS) begin
        next_s.pins = sfr_wdata_in & PINS_MASK;
      end else if (sfr_addr_in == OFF_AUXILIARY_CONTROL_ONE) begin
        next_s.auxiliary_control_one = sfr_wdata_in & AUXILIARY_CONTROL_ONE_MASK;
      end
    end

    // reads take effect on the next edge; unmapped addresses read zero
    if (sfr_rd_in) begin
      next_s.rdata = UNMAPPED_READ;
      for (int i = 0; i < CHAN_N; i++) begin
        if (sfr_addr_in == OFF_PERIOD[i]) begin
          next_s.rdata = s.period[i];
        end else if (sfr_addr_in == OFF_DUTY_HIGH[i]) begin
          next_s.rdata = s.duty_high[i];
        end
      end
      if (sfr_addr_in == OFF_CON01) begin
        next_s.rdata = s.con01;
      end else if (sfr_addr_in == OFF_CON2) begin
        next_s.rdata = s.con2;
      end else if (sfr_addr_in == OFF_PINS) begin
        next_s.rdata = s.pins;
      end else if (sfr_addr_in == OFF_AUXILIARY_CONTROL_ONE) begin
        next_s.rdata = s.auxiliary_control_one;
      end
    end

    // open-drain only ever pulls low; high comes from the external pull-up
    for (int i = 0; i < CHAN_N; i++) begin
      if (chan_open_drain_in[i]) begin
        next_s.pin_out[i] = 1'b0;
        next_s.pin_oe[i]  = chan_oe[i] && !wave[i];
      end else begin
        next_s.pin_out[i] = chan_oe[i] && wave[i];
        next_s.pin_oe[i]  = chan_oe[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s.period    <= {CHAN_N{PERIOD_RST}};
      s.duty_high <= {CHAN_N{DUTY_HIGH_RST}};
      s.con01     <= CON01_RST;
      s.con2      <= CON2_RST;
      s.pins      <= PINS_RST;
      s.auxiliary_control_one      <= AUXILIARY_CONTROL_ONE_RST;
      s.rdata     <= UNMAPPED_READ;
      s.pin_out   <= '0;
      s.pin_oe    <= '0;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign sfr_rdata_out        = s.rdata;
  assign modulator_pin_out    = s.pin_out;
  assign modulator_pin_oe_out = s.pin_oe;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_period_write : assert property (
    (ce_in && sfr_wr_in && sfr_addr_in == OFF_PERIOD[1]) |=> s.period[1] == $past(sfr_wdata_in))
    else $error("period register did not take written value");

  a_duty_readback : assert property (
    (ce_in && sfr_wr_in && sfr_addr_in == OFF_DUTY_HIGH[0])
      ##1 (ce_in && sfr_rd_in && !sfr_wr_in && sfr_addr_in == OFF_DUTY_HIGH[0])
      |=> sfr_rdata_out == $past(sfr_wdata_in, 2))
    else $error("duty high byte read back wrong");

  a_unmapped_zero : assert property (
    (ce_in && sfr_rd_in && sfr_addr_in == 8'ha0) |=> sfr_rdata_out == UNMAPPED_READ)
    else $error("unmapped read not zero");

  a_disabled_pin : assert property (
    (!chan_oe[1] && ce_in) [*2] |-> !modulator_pin_out[1] && !modulator_pin_oe_out[1])
    else $error("disabled channel still drives pin");

  a_clear_holds : assert property (
    (clear0 && ce_in) [*3] |-> !wave[0] && !modulator_pin_out[0])
    else $error("cleared channel 0 not held low");

  a_no_clear_ch2 : assert property (
    (clear0 && chan_oe[2]) |-> ch[2].run)
    else $error("clear control stopped channel 2");

  a_open_drain : assert property (
    $past(chan_open_drain_in[2] && ce_in) |-> !modulator_pin_out[2])
    else $error("open-drain pin driven high");

  a_duty_mux : assert property (
    (ce_in && sfr_wr_in && sfr_addr_in == OFF_CON01)
      |=> ch[1].duty_lo == $past(sfr_wdata_in[DL_LSB[1] +: 2]))
    else $error("duty low bits not routed to channel 1");

  c_ch0_runs   : cover property (chan_run[0] ##1 modulator_pin_out[0] ##[1:300] !modulator_pin_out[0]);
  c_ch2_frc    : cover property (cks[2] == CKS_FRC && wave[2]);
  c_clear_hold : cover property (wave[0] ##1 clear0);
  c_od_pull    : cover property (chan_open_drain_in[1] && modulator_pin_oe_out[1]);

endmodule
`default_nettype wire

// File: test/tcdp_load_model.sv
// Purpose: pulled-up load on the three modulator pins, counting levels
// Assumes: a pin that is not driven floats up through the pull-up
// Notes: counts restart on clr_in; level is what an rc filter would see
`timescale 1ns/1ps
`default_nettype none
module tcdp_load_model (
  input  wire logic             clk_in,   // system clock
  input  wire logic [2:0]       pin_in,   // pin drive level
  input  wire logic [2:0]       oe_in,    // pin output enable
  input  wire logic             clr_in,   // restart counts
  output logic      [2:0][15:0] high_out, // cycles seen high
  output logic      [2:0][15:0] oe_out    // cycles driven
);
  logic [2:0] level;

  // open-drain highs only come from the pull-up, never from the driver
  assign level = (oe_in & pin_in) | ~oe_in;

  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 3; i++) begin
      high_out[i] <= clr_in ? 16'h0000 : high_out[i] + 16'(level[i]);
      oe_out[i]   <= clr_in ? 16'h0000 : oe_out[i] + 16'(oe_in[i]);
    end
  end
endmodule
`default_nettype wire

// File: test/tcdp_test.sv
// Purpose: register and waveform tests of the three-channel modulator
// Assumes: pulled-up load on every pin, fast rc pulse every 3 clocks
// Notes: high time is counted over one whole dither cycle, so phase is moot
`timescale 1ns/1ps
`default_nettype none
module tcdp_test;
  import tcdp_pkg::*;
  logic             clk_in       = 1'b0;
  logic             rst_n_in     = 1'b0;
  logic             ce_in        = 1'b1;
  logic [7:0]       sfr_addr_in  = 8'h00;
  logic             sfr_wr_in    = 1'b0;
  logic             sfr_rd_in    = 1'b0;
  logic [7:0]       sfr_wdata_in = 8'h00;
  logic [7:0]       sfr_rdata_out;
  logic             fast_rc_oscillator          = 1'b0;
  logic [1:0]       frc_cnt      = 2'h0;
  logic [2:0]       od           = 3'h0;
  logic [2:0]       pin;
  logic [2:0]       pin_oe;
  logic             clr          = 1'b0;
  logic [2:0][15:0] high_cnt;
  logic [2:0][15:0] oe_cnt;
  logic [7:0]       d;
  logic [2:0]       held;
  int               miscompares  = 0;
  int               cmp_count    = 0;
  int               cycles       = 0;
  int               w;
  int               hi;
  int               divs [4]     = '{4, 2, 1, 3};
  logic [7:0] addrs [11] = '{8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9e, 8'h9f,
                             8'ha1, 8'ha6, 8'ha7, 8'hf8, 8'ha0};
  logic [7:0] rstv [11]  = '{8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00,
                             8'h88, 8'h00, 8'h08, 8'h00, 8'h00};
  logic [7:0] masks [11] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                             8'hff, 8'hc0, 8'h1f, 8'h08, 8'h00};

  tcdp_top i_tcdp_top (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .fast_rc_oscillator_in(fast_rc_oscillator), .chan_open_drain_in(od),
    .modulator_pin_out(pin), .modulator_pin_oe_out(pin_oe));

  tcdp_load_model i_tcdp_load_model (
    .clk_in(clk_in), .pin_in(pin), .oe_in(pin_oe), .clr_in(clr),
    .high_out(high_cnt), .oe_out(oe_cnt));

  always #5 clk_in = ~clk_in;

  // fast rc stand-in: one pulse every third clock
  always @(posedge clk_in) begin
    frc_cnt <= (frc_cnt == 2'h2) ? 2'h0 : frc_cnt + 2'h1;
    fast_rc_oscillator <= (frc_cnt == 2'h2);
  end

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= v;
    sfr_wr_in <= 1'b1;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(posedge clk_in);
    sfr_rd_in <= 1'b0;
    #1;
    d = sfr_rdata_out;
  endtask

  // counts cover exactly n clocks after the restart edge
  task automatic measure(input int n);
    @(posedge clk_in);
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic run(input int ch, input logic [7:0] p, input logic [7:0] dh,
                     input logic [1:0] dl, input logic [1:0] cks, output int n);
    wr(OFF_PINS, 8'h00);
    wr(OFF_CON2, 8'h00);
    // clear-hold must not touch channels 1 and 2
    wr(OFF_AUXILIARY_CONTROL_ONE, (ch == 0) ? 8'h00 : 8'h08);
    wr(OFF_PERIOD[ch], p);
    wr(OFF_DUTY_HIGH[ch], dh);
    if (ch == 2) begin
      wr(OFF_CON2, {3'h0, 1'b1, cks, dl});
    end else begin
      wr(OFF_CON01, 8'({cks, dl}) << DL_LSB[ch]);
      wr(OFF_PINS, 8'h01 << OE_BIT[ch]);
    end
    n = 4 * (int'(p) + 1) * divs[cks];
    repeat (n) @(posedge clk_in);
    measure(n);
  endtask

  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    foreach (addrs[i]) begin
      rd(addrs[i]);
      check({8'h00, d}, {8'h00, rstv[i]});
    end
    $display("test reset values done");
    foreach (addrs[i]) begin
      wr(addrs[i], 8'hff);
      rd(addrs[i]);
      check({8'h00, d}, {8'h00, masks[i]});
    end
    // write then read on the very next edge, no idle cycle between
    @(posedge clk_in);
    sfr_addr_in  <= OFF_DUTY_HIGH[0];
    sfr_wdata_in <= 8'h5a;
    sfr_wr_in    <= 1'b1;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
    sfr_rd_in <= 1'b1;
    @(posedge clk_in);
    sfr_rd_in <= 1'b0;
    @(posedge clk_in);
    check({8'h00, sfr_rdata_out}, 16'h005a);
    $display("test register access done");
    for (int ch = 0; ch < 3; ch++) begin
      for (int c = 0; c < 4; c++) begin
        for (int l = 0; l < 4; l++) begin
          @(posedge clk_in);
          od <= l[0] ? (3'h1 << ch) : 3'h0;
          run(ch, 8'(3 + ch), 8'(2 + ch), 2'(l), 2'(c), w);
          hi = divs[c] * (4 * (2 + ch) - l);
          check(high_cnt[ch], 16'(hi));
          check(oe_cnt[ch], 16'(l[0] ? w - hi : w));
        end
      end
    end
    $display("test waveform sweep done");
    @(posedge clk_in);
    od <= 3'h0;
    run(0, 8'h03, 8'h02, 2'h0, 2'h2, w);
    // strobes and counting both freeze while the clock enable is low
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(OFF_PERIOD[0], 8'h55);
    held = pin;
    repeat (5) @(posedge clk_in);
    check({13'h0000, pin}, {13'h0000, held});
    ce_in <= 1'b1;
    rd(OFF_PERIOD[0]);
    check({8'h00, d}, 16'h0003);
    wr(OFF_AUXILIARY_CONTROL_ONE, 8'h08);
    measure(w);
    check(high_cnt[0], 16'h0000);
    wr(OFF_AUXILIARY_CONTROL_ONE, 8'h00);
    repeat (w) @(posedge clk_in);
    measure(w);
    check(high_cnt[0], 16'h0008);
    wr(OFF_PINS, 8'h00);
    measure(w);
    check(oe_cnt[0], 16'h0000);
    check(high_cnt[0], 16'(w));
    run(0, 8'h03, 8'h00, 2'h0, 2'h2, w);
    check(high_cnt[0], 16'h0000);
    $display("test clear and disable done");
    end_of_test();
  end
endmodule
`default_nettype wire
